// file: src/sapc_top.sv
// Control logic of the 12-bit successive approximation converter.
// Assumes pin inputs are asynchronous to sys_clk; comparator is a pin too.
`default_nettype none
`include "sapc_consts.svh"
module sapc_top #(
  parameter int RES_BITS   = `SAPC_RES_BITS,
  parameter int BIT_CYCLES = `SAPC_BIT_CYCLES
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                conversion_trigger_n,
  input  wire logic                chip_select_n,
  input  wire logic                read_n,
  input  wire logic                power_down_n,
  input  wire logic                shutdown_kind_select,
  input  wire logic                comparator_high,
  output logic                     busy_n,
  output logic [RES_BITS-1:0]      result_bits,
  output logic                     result_oe_n,
  output logic                     dac_trial_valid,
  output logic [RES_BITS-1:0]      dac_trial_code,
  output sapc_pkg::sapc_power_down_n_s     shutdown_ff
);
  // ******************************
  // Checks
  // ******************************
  // Comparator answer needs six cycles: trial register, DAC copy, synchroniser
  if (RES_BITS != 12 || BIT_CYCLES < 6 || BIT_CYCLES > 256) begin : g_bad_params
    $error("sapc_top: unsupported parameters");
  end

  // ******************************
  // Input synchronisers
  // ******************************
  // Three stages; a change counts once stages two and three agree
  localparam int NIN = 6;
  logic [NIN-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
  logic [NIN-1:0] nxt_clean;
  logic [NIN-1:0] raw;
  assign raw = {comparator_high, shutdown_kind_select, power_down_n, read_n, chip_select_n, conversion_trigger_n};
  always_comb begin
    nxt_clean = clean_ff;
    for (int i = 0; i < NIN; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_clean[i] = s3_ff[i];
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_ff    <= 6'h3f;
      s2_ff    <= 6'h3f;
      s3_ff    <= 6'h3f;
      clean_ff <= 6'h3f;
    end else begin
      s1_ff    <= raw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      clean_ff <= nxt_clean;
    end
  end
  logic trig_n, cs_n, rd_n, pd_n, kind, cmp;
  assign {cmp, kind, pd_n, rd_n, cs_n, trig_n} = clean_ff;

  // ******************************
  // Start detection
  // ******************************
  logic trig_prev_ff;
  logic trig_fall;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trig_prev_ff <= 1'b1;
    end else begin
      trig_prev_ff <= trig_n;
    end
  end
  // Edge only, gated by select; level never restarts
  assign trig_fall = trig_prev_ff & ~trig_n & ~cs_n;

  // ******************************
  // Successive approximation sequencer
  // ******************************
  // Internal pacing only, no host clock involved
  sapc_pkg::sapc_state_e  state_ff, nxt_state;
  logic [RES_BITS-1:0]    trial_ff, nxt_trial;
  logic [RES_BITS-1:0]    mask_ff, nxt_mask;
  logic [RES_BITS-1:0]    result_ff, nxt_result;
  logic [7:0]             tick_ff, nxt_tick;
  logic                   busy_ff, nxt_busy;
  sapc_pkg::sapc_power_down_n_s   nxt_power_down_n;

  always_comb begin
    nxt_state  = state_ff;
    nxt_trial  = trial_ff;
    nxt_mask   = mask_ff;
    nxt_result = result_ff;
    nxt_tick   = tick_ff;
    nxt_busy   = busy_ff;
    nxt_power_down_n.active = ~pd_n;
    nxt_power_down_n.nap    = kind;
    case (state_ff)
      sapc_pkg::SAPC_IDLE: begin
        nxt_busy = 1'b1;
        if (!pd_n) begin
          nxt_state = sapc_pkg::SAPC_DOWN;
        end else if (trig_fall) begin
          nxt_state = sapc_pkg::SAPC_CONV;
          // Clear, then place MSB trial
          nxt_trial = {1'b1, {(RES_BITS-1){1'b0}}};
          nxt_mask  = {1'b1, {(RES_BITS-1){1'b0}}};
          nxt_tick  = 8'(BIT_CYCLES - 1);
          nxt_busy  = 1'b0;
        end
      end
      sapc_pkg::SAPC_CONV: begin
        // Trigger edges ignored here
        nxt_busy = 1'b0;
        if (tick_ff != 8'h00) begin
          nxt_tick = tick_ff - 8'h01;
        end else begin
          // Keep bit if DAC still below input
          if (!cmp) begin
            nxt_trial = trial_ff & ~mask_ff;
          end
          nxt_trial = nxt_trial | (mask_ff >> 1);
          nxt_mask  = mask_ff >> 1;
          nxt_tick  = 8'(BIT_CYCLES - 1);
          if (mask_ff[0]) begin
            nxt_trial  = cmp ? trial_ff : (trial_ff & ~mask_ff);
            // Offset binary to two's complement by MSB flip
            nxt_result = {~nxt_trial[RES_BITS-1], nxt_trial[RES_BITS-2:0]};
            nxt_busy   = 1'b1;
            nxt_state  = sapc_pkg::SAPC_IDLE;
          end
        end
      end
      sapc_pkg::SAPC_DOWN: begin
        nxt_busy = 1'b1;
        if (pd_n) begin
          nxt_state = sapc_pkg::SAPC_IDLE;
        end
      end
      default: begin
        nxt_state = sapc_pkg::SAPC_IDLE;
        nxt_busy  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff    <= sapc_pkg::SAPC_IDLE;
      trial_ff    <= `SAPC_RESULT_RST;
      mask_ff     <= `SAPC_RESULT_RST;
      result_ff   <= `SAPC_RESULT_RST;
      tick_ff     <= 8'h00;
      busy_ff     <= 1'b1;
      shutdown_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      trial_ff    <= nxt_trial;
      mask_ff     <= nxt_mask;
      result_ff   <= nxt_result;
      tick_ff     <= nxt_tick;
      busy_ff     <= nxt_busy;
      shutdown_ff <= nxt_power_down_n;
    end
  end

  // ******************************
  // Output port
  // ******************************
  logic oe_ff, nxt_oe;
  logic dac_v_ff, nxt_dac_v;
  logic [RES_BITS-1:0] dac_ff, outq_ff;
  always_comb begin
    nxt_oe    = ~(~rd_n & ~cs_n);
    nxt_dac_v = (state_ff == sapc_pkg::SAPC_CONV);
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      oe_ff    <= 1'b1;
      dac_v_ff <= 1'b0;
      dac_ff   <= `SAPC_RESULT_RST;
      outq_ff  <= `SAPC_RESULT_RST;
    end else begin
      oe_ff    <= nxt_oe;
      dac_v_ff <= nxt_dac_v;
      dac_ff   <= trial_ff;
      outq_ff  <= nxt_result;
    end
  end
  // Latch copy loads in the same cycle as result; busy lags one cycle, so data leads busy
  logic busy_q_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_q_ff <= 1'b1;
    end else begin
      busy_q_ff <= busy_ff;
    end
  end
  assign busy_n          = busy_q_ff;
  assign result_bits     = outq_ff;
  assign result_oe_n     = oe_ff;
  assign dac_trial_valid = dac_v_ff;
  assign dac_trial_code  = dac_ff;

  // ******************************
  // Assertions
  // ******************************
  sequence s_start;
    $fell(trig_n) && trig_prev_ff == 1'b1 && !cs_n && state_ff == sapc_pkg::SAPC_IDLE && pd_n;
  endsequence
  property p_start_busy;
    @(posedge sys_clk) disable iff (srst) s_start |-> ##2 !busy_n;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy did not fall on start");
  property p_no_start_cs;
    @(posedge sys_clk) disable iff (srst) (state_ff == sapc_pkg::SAPC_IDLE && cs_n) |=> state_ff != sapc_pkg::SAPC_CONV;
  endproperty
  a_no_start_cs: assert property (p_no_start_cs) else $error("start without select");
  property p_oe;
    @(posedge sys_clk) disable iff (srst) (!rd_n && !cs_n) |=> !result_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("drivers not enabled");
  property p_oe_off;
    @(posedge sys_clk) disable iff (srst) (rd_n || cs_n) |=> result_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drivers left on");
  property p_data_ready;
    @(posedge sys_clk) disable iff (srst) $rose(busy_n) |-> result_bits == $past(result_ff);
  endproperty
  a_data_ready: assert property (p_data_ready) else $error("result not ready at busy rise");
  property p_no_restart;
    @(posedge sys_clk) disable iff (srst) (state_ff == sapc_pkg::SAPC_CONV && !mask_ff[0]) |=> state_ff == sapc_pkg::SAPC_CONV;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion cut short");
  property p_down_busy;
    @(posedge sys_clk) disable iff (srst) (state_ff == sapc_pkg::SAPC_DOWN) |=> ##1 busy_n;
  endproperty
  a_down_busy: assert property (p_down_busy) else $error("busy low in shutdown");
  property p_power_down_n;
    @(posedge sys_clk) disable iff (srst) 1'b1 |=> shutdown_ff.active == !$past(pd_n) && shutdown_ff.nap == $past(kind);
  endproperty
  a_power_down_n: assert property (p_power_down_n) else $error("shutdown state wrong");
  property p_clear;
    @(posedge sys_clk) disable iff (srst) (state_ff == sapc_pkg::SAPC_IDLE && nxt_state == sapc_pkg::SAPC_CONV) |=> trial_ff == 12'h800;
  endproperty
  a_clear: assert property (p_clear) else $error("trial not cleared");
  // Bit slot steps
  sequence s_next_bit;
    state_ff == sapc_pkg::SAPC_CONV && tick_ff == 8'h00 && !mask_ff[0];
  endsequence
  sequence s_last_bit;
    state_ff == sapc_pkg::SAPC_CONV && tick_ff == 8'h00 && mask_ff[0];
  endsequence
  property p_mask_shift;
    @(posedge sys_clk) disable iff (srst) s_next_bit |=> mask_ff == ($past(mask_ff) >> 1);
  endproperty
  a_mask_shift: assert property (p_mask_shift) else $error("trial bit did not step down");
  property p_mask_onehot;
    @(posedge sys_clk) disable iff (srst) (state_ff == sapc_pkg::SAPC_CONV) |-> $onehot(mask_ff);
  endproperty
  a_mask_onehot: assert property (p_mask_onehot) else $error("more than one bit on trial");
  property p_trial_hold;
    @(posedge sys_clk) disable iff (srst)
      (state_ff == sapc_pkg::SAPC_CONV && tick_ff != 8'h00) |=> $stable(trial_ff) && $stable(mask_ff);
  endproperty
  a_trial_hold: assert property (p_trial_hold) else $error("trial changed inside a bit slot");
  property p_finish;
    @(posedge sys_clk) disable iff (srst)
      s_last_bit |=> (state_ff == sapc_pkg::SAPC_IDLE &&
                      result_bits == {~trial_ff[RES_BITS-1], trial_ff[RES_BITS-2:0]}) ##1 busy_n;
  endproperty
  a_finish: assert property (p_finish) else $error("result not latched before busy rise");
  property p_busy_low;
    @(posedge sys_clk) disable iff (srst) (state_ff == sapc_pkg::SAPC_CONV) |=> !busy_n;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy high during conversion");
  property p_idle_busy;
    @(posedge sys_clk) disable iff (srst)
      (state_ff == sapc_pkg::SAPC_IDLE) ##1 (state_ff == sapc_pkg::SAPC_IDLE) |=> busy_n;
  endproperty
  a_idle_busy: assert property (p_idle_busy) else $error("busy low while idle");
  property p_no_start_down;
    @(posedge sys_clk) disable iff (srst) (state_ff == sapc_pkg::SAPC_IDLE && !pd_n) |=> state_ff != sapc_pkg::SAPC_CONV;
  endproperty
  a_no_start_down: assert property (p_no_start_down) else $error("start while powered down");
  property p_level_no_start;
    @(posedge sys_clk) disable iff (srst)
      (state_ff == sapc_pkg::SAPC_IDLE && !trig_prev_ff) |=> state_ff != sapc_pkg::SAPC_CONV;
  endproperty
  a_level_no_start: assert property (p_level_no_start) else $error("start on trigger level");
  // Conversion length, checker only; one count per cycle in conversion
  localparam int       CONV_LEN = RES_BITS * BIT_CYCLES;
  logic [15:0]         conv_len_ff, nxt_conv_len;
  always_comb begin
    nxt_conv_len = conv_len_ff;
    if (state_ff == sapc_pkg::SAPC_CONV) begin
      nxt_conv_len = conv_len_ff + 16'h0001;
    end else begin
      nxt_conv_len = 16'h0000;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_len_ff <= 16'h0000;
    end else begin
      conv_len_ff <= nxt_conv_len;
    end
  end
  property p_conv_len;
    @(posedge sys_clk) disable iff (srst)
      (state_ff == sapc_pkg::SAPC_CONV && nxt_state == sapc_pkg::SAPC_IDLE) |-> conv_len_ff == 16'(CONV_LEN - 1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
endmodule
`default_nettype wire

// file: src/sapc_consts.svh
// Constants of the converter control block: widths, timing counts.
// Assumes a 100 MHz sys_clk; included by sapc_pkg and the top module.
// How it works
// - Low power-down input enters shutdown of the currently selected kind.
// - Kind select low means sleep, high means nap; host chooses.
// - Result drivers enabled only while read strobe and select are low.
// - Result is a 12-bit word, MSB on the top result line.
// - Conversion starts on trigger falling edge, never on its level.
// - Trigger and read strobe ignored unless device select is low.
// - Busy is low throughout a conversion and rises at its end.
// - New result sits in output latches by busy rising edge.
// - Bit-trial register cleared at conversion start before first decision.
// - Trigger edges during a running conversion are ignored.
// - Bits resolved one per step from MSB down to LSB.
// - Finished trial register, positive minus negative, loaded into latches.
// - Conversion paced by the internal clock; host gives only the trigger.
// - Result is two's complement, one step is full span over 4096.
`ifndef SAPC_CONSTS_SVH
`define SAPC_CONSTS_SVH
`define SAPC_RES_BITS      12
`define SAPC_BIT_TIME_NS   70
`define SAPC_CLK_PERIOD_NS 10
`define SAPC_BIT_CYCLES    ((`SAPC_BIT_TIME_NS + `SAPC_CLK_PERIOD_NS - 1) / `SAPC_CLK_PERIOD_NS)
`define SAPC_RESULT_RST    12'h000
`endif

// file: src/sapc_pkg.sv
// Types shared by the converter control block.
// Assumes sapc_consts.svh is on the include path.
`default_nettype none
`include "sapc_consts.svh"
package sapc_pkg;
  typedef enum logic [1:0] {
    SAPC_IDLE,
    SAPC_CONV,
    SAPC_DOWN
  } sapc_state_e;
  typedef struct packed {
    logic                       active;
    logic                       nap;
  } sapc_power_down_n_s;
endpackage
`default_nettype wire

// file: testbench/sapc_input_model.sv
// Analog input stand-in: comparator answer for a held input code.
// Assumes trial code is offset binary, target is two's complement.
`default_nettype none
module sapc_input_model (
  input  wire logic [11:0] dac_trial_code,
  input  wire logic [11:0] target,
  output logic             comparator_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Keep the trial bit while input is at or above the DAC level
  assign comparator_high = ({~target[11], target[10:0]} >= dac_trial_code);
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Bench for the converter control block: conversions, reads, shutdown.
// Assumes sapc_top from src/ and sapc_input_model as the analog side.
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 7;
  logic                 sys_clk = 1'b0;
  logic                 srst    = 1'b1;
  logic                 trig_n  = 1'b1;
  logic                 cs_n    = 1'b1;
  logic                 rd_n    = 1'b1;
  logic                 pd_n    = 1'b1;
  logic                 kind    = 1'b1;
  logic [11:0]          target  = 12'h000;
  logic                 cmp_high;
  logic                 busy_n;
  logic [11:0]          result_bits;
  logic                 result_oe_n;
  logic                 dac_trial_valid;
  logic [11:0]          dac_trial_code;
  sapc_pkg::sapc_power_down_n_s shutdown_ff;
  int                   err_count = 0;
  int                   n_checks  = 0;
  int                   n;
  logic [11:0]          codes[5] = '{12'h7ff, 12'h800, 12'h000, 12'hfff, 12'ha5a};

  initial forever #5 sys_clk = ~sys_clk;

  sapc_top #(.BIT_CYCLES(BC)) DUT (
    .sys_clk              (sys_clk),
    .srst                 (srst),
    .conversion_trigger_n (trig_n),
    .chip_select_n        (cs_n),
    .read_n               (rd_n),
    .power_down_n         (pd_n),
    .shutdown_kind_select (kind),
    .comparator_high      (cmp_high),
    .busy_n               (busy_n),
    .result_bits          (result_bits),
    .result_oe_n          (result_oe_n),
    .dac_trial_valid      (dac_trial_valid),
    .dac_trial_code       (dac_trial_code),
    .shutdown_ff          (shutdown_ff)
  );

  sapc_input_model u_input (
    .dac_trial_code  (dac_trial_code),
    .target          (target),
    .comparator_high (cmp_high)
  );

  // ****************************************
  // Pin access tasks
  // ****************************************
  task automatic wait_busy(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (busy_n !== lvl && cnt < lim) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask

  // Glitch gives a second falling edge mid-conversion
  task automatic convert(input logic [11:0] tgt, input bit glitch);
    int len;
    target = tgt;
    cs_n = 1'b0;
    @(negedge sys_clk);
    trig_n = 1'b0;
    wait_busy(1'b0, 20, len);
    `CHK("busy fall", 1'b0, busy_n)
    `CHK("trial start", 12'h800, dac_trial_code)
    `CHK("trial valid", 1'b1, dac_trial_valid)
    if (glitch) begin
      repeat (20) @(negedge sys_clk);
      trig_n = 1'b1;
      repeat (10) @(negedge sys_clk);
      trig_n = 1'b0;
    end
    wait_busy(1'b1, 200, len);
    len = len + (glitch ? 30 : 0);
    `CHK("busy length", 1'b1, (len >= 12 * BC - 2) && (len <= 12 * BC + 3))
    `CHK("result at busy rise", tgt, result_bits)
    `CHK("trial idle", 1'b0, dac_trial_valid)
    // Trigger still low: level must not restart
    wait_busy(1'b0, 30, len);
    `CHK("level restart", 30, len)
    trig_n = 1'b1;
    cs_n = 1'b1;
    repeat (16) @(negedge sys_clk);
  endtask

  task automatic read_word(input logic sel_n, input logic [11:0] exp);
    cs_n = sel_n;
    rd_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK("oe on read", sel_n, result_oe_n)
    if (!sel_n) begin
      `CHK("read word", exp, result_bits)
    end
    rd_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("oe released", 1'b1, result_oe_n)
    cs_n = 1'b1;
    @(negedge sys_clk);
  endtask

  task automatic final_report();
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    `CHK("reset busy", 1'b1, busy_n)
    `CHK("reset oe", 1'b1, result_oe_n)
    foreach (codes[i]) begin
      convert(codes[i], i == 2);
      read_word(1'b0, codes[i]);
    end
    read_word(1'b1, 12'h000);
    trig_n = 1'b0;
    wait_busy(1'b0, 30, n);
    `CHK("start without select", 30, n)
    trig_n = 1'b1;
    for (int k = 1; k >= 0; k--) begin
      kind = k[0];
      repeat (2) @(negedge sys_clk);
      pd_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      `CHK("shutdown kind", {1'b1, k[0]}, shutdown_ff)
      cs_n = 1'b0;
      trig_n = 1'b0;
      wait_busy(1'b0, 30, n);
      `CHK("start while down", 30, n)
      trig_n = 1'b1;
      cs_n = 1'b1;
      pd_n = 1'b1;
      repeat (25) @(negedge sys_clk);
      `CHK("awake", {1'b0, k[0]}, shutdown_ff)
      convert(12'h123, 1'b0);
    end
    final_report();
  end

  // Seven conversions and the idle checks take under 2000 cycles
  initial begin
    #100_000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
